// >>> verilog/spi_eeprom_pkg.sv
// Constants and types shared by the serial EEPROM slave front end
package spi_eeprom_pkg;
	localparam int          ADDR_W           = 16;
	localparam int          MEM_DEPTH        = 65536;
	localparam int          PAGE_BYTES       = 128;
	localparam int          PAGE_W           = 7;
	localparam int          CNT_W            = 5;
	localparam int          TIMER_W          = 21;
	localparam int          CLK_PERIOD_NS    = 5;
	localparam int          WRITE_TIME_MS    = 5;
	// Longest write time rounded down to whole clk_sys cycles
	localparam int          WRITE_CYCLES_DEF = WRITE_TIME_MS * 1000000 / CLK_PERIOD_NS;
	localparam logic [7:0]  OPCODE_MASK      = 8'hF7;
	localparam logic [7:0]  set_write_latch_cmd   = 8'h06;
	localparam logic [7:0]  clear_write_latch_cmd = 8'h04;
	localparam logic [7:0]  read_status_cmd       = 8'h05;
	localparam logic [7:0]  write_status_cmd      = 8'h01;
	localparam logic [7:0]  read_array_cmd        = 8'h03;
	localparam logic [7:0]  write_array_cmd       = 8'h02;
	localparam logic [CNT_W-1:0] CNT_FIRST   = 5'h00;
	localparam logic [CNT_W-1:0] CMD_LAST    = 5'h07;
	localparam logic [CNT_W-1:0] STAT_LAST   = 5'h0F;
	localparam logic [CNT_W-1:0] ADDR_HI_END = 5'h0F;
	localparam logic [CNT_W-1:0] ADDR_LO_END = 5'h17;
	localparam logic [CNT_W-1:0] DATA_FIRST  = 5'h18;
	localparam logic [CNT_W-1:0] DATA_LAST   = 5'h1F;
	localparam logic [CNT_W-1:0] CMD_BITS    = 5'h08;
	localparam logic [2:0]  BIT_LAST    = 3'h7;
	localparam logic [1:0]  BP_NONE     = 2'h0;
	localparam logic [1:0]  BP_QUARTER  = 2'h1;
	localparam logic [1:0]  BP_HALF     = 2'h2;
	localparam logic [1:0]  TOP_QUARTER = 2'h3;
	localparam logic [7:0]  STATUS_BUSY = 8'hFF;

	typedef struct packed {
		logic       pin_protect_enable_bit;
		logic [2:0] spare;
		logic       block_protect_high_bit;
		logic       block_protect_low_bit;
		logic       write_latch;
		logic       busy;
	} status_t;

	typedef enum logic [1:0] {ST_IDLE, ST_PROG, ST_WAIT} prog_state_t;
endpackage : spi_eeprom_pkg

// >>> verilog/spi_eeprom_slave_interface.sv
// Serial slave front end of a 64K x 8 nonvolatile byte memory
`timescale 1ns/10ps
module spi_eeprom_slave_interface
	import spi_eeprom_pkg::*;
#(
	parameter int WRITE_CYCLES = WRITE_CYCLES_DEF
) (
	input  wire logic clk_sys,
	input  wire logic rstn,
	input  wire logic spi_sck,
	input  wire logic cs_n,
	input  wire logic si,
	input  wire logic hold_n,
	input  wire logic wp_n,
	output logic      so_o,
	output logic      so_oe,
	output logic      busy
);
	logic [7:0]             mem [MEM_DEPTH];
	logic [7:0]             page_mem [PAGE_BYTES];
	// Link side, on the serial clock
	logic [CNT_W-1:0]       cnt_ff;
	logic                   bad_ff;
	logic [7:0]             in_sr_ff;
	logic [7:0]             op_ff;
	logic                   cmd_ok_ff;
	logic                   whole_ff;
	logic                   sgot_ff;
	logic [7:0]             stat_byte_ff;
	logic [ADDR_W-1:0]      addr_ff;
	logic [PAGE_BYTES-1:0]  mask_ff;
	logic [7:0]             out_sr_ff;
	logic                   so_ff;
	logic                   so_oe_ff;
	status_t                stat_s1_ff;
	status_t                stat_s2_ff;
	// System side
	logic                   cs_s1_ff;
	logic                   cs_s2_ff;
	logic                   cs_d_ff;
	logic                   wp_s1_ff;
	logic                   wp_s2_ff;
	logic                   wp_drop_ff;
	status_t                stat_ff;
	prog_state_t            st_ff;
	logic [PAGE_W-1:0]      idx_ff;
	logic [ADDR_W-PAGE_W-1:0] page_ff;
	logic [TIMER_W-1:0]     timer_ff;
	logic                   busy_ff;
	logic [PAGE_BYTES-1:0]  wmask_ff;

	wire link_rst_n = rstn & ~cs_n;
	wire [7:0] in_byte  = {in_sr_ff[6:0], si};
	wire [7:0] op_in    = in_byte & OPCODE_MASK;
	wire op_known = op_in == set_write_latch_cmd || op_in == clear_write_latch_cmd
		|| op_in == read_status_cmd || op_in == write_status_cmd
		|| op_in == read_array_cmd || op_in == write_array_cmd;
	// Only status reads are accepted while a write cycle runs
	wire op_valid   = op_known && (!stat_s2_ff.busy || op_in == read_status_cmd);
	wire step       = hold_n && !bad_ff;
	wire byte_end   = cnt_ff[2:0] == BIT_LAST;
	wire data_phase = cnt_ff >= DATA_FIRST;
	wire [CNT_W-1:0] nxt_cnt = (cnt_ff == DATA_LAST) ? DATA_FIRST : cnt_ff + 5'h01;
	wire is_rd_stat = op_ff == read_status_cmd;
	wire is_rd_arr  = op_ff == read_array_cmd;
	wire is_wr_arr  = op_ff == write_array_cmd;
	wire is_wr_stat = op_ff == write_status_cmd;
	wire out_phase  = !bad_ff && cmd_ok_ff
		&& ((is_rd_stat && cnt_ff >= CMD_BITS) || (is_rd_arr && data_phase));
	// Status reads while a write cycle runs return all ones
	wire [7:0] stat_view = stat_s2_ff.busy ? STATUS_BUSY : 8'(stat_s2_ff);
	wire [7:0] out_byte = is_rd_stat ? stat_view : mem[addr_ff];
	wire [PAGE_W-1:0] nxt_pg_addr = addr_ff[PAGE_W-1:0] + 7'h01;

	// Frame position; cleared whenever select is high, frozen while paused
	always_ff @(posedge spi_sck or negedge link_rst_n) begin
		if (!link_rst_n) begin
			cnt_ff <= CNT_FIRST;
			bad_ff <= 1'b0;
		end else if (step) begin
			cnt_ff <= nxt_cnt;
			bad_ff <= cnt_ff == CMD_LAST && !op_valid;
		end
	end

	// Frame contents survive deselect so the system side can act on them
	always_ff @(posedge spi_sck or negedge rstn) begin
		if (!rstn) begin
			in_sr_ff     <= 8'h00;
			op_ff        <= 8'h00;
			cmd_ok_ff    <= 1'b0;
			whole_ff     <= 1'b0;
			sgot_ff      <= 1'b0;
			stat_byte_ff <= 8'h00;
			addr_ff      <= '0;
			mask_ff      <= '0;
		end else if (!cs_n && step) begin
			in_sr_ff <= in_byte;
			whole_ff <= byte_end;
			if (cnt_ff == CNT_FIRST) begin
				cmd_ok_ff <= 1'b0;
				sgot_ff   <= 1'b0;
				mask_ff   <= '0;
			end
			if (cnt_ff == CMD_LAST) begin
				op_ff     <= op_in;
				cmd_ok_ff <= op_valid;
			end
			if (cnt_ff == STAT_LAST && is_wr_stat) begin
				stat_byte_ff <= in_byte;
				sgot_ff      <= 1'b1;
			end
			if (cnt_ff == ADDR_HI_END && (is_rd_arr || is_wr_arr))
				addr_ff[15:8] <= in_byte;
			if (cnt_ff == ADDR_LO_END && (is_rd_arr || is_wr_arr))
				addr_ff[7:0] <= in_byte;
			if (data_phase && byte_end && is_rd_arr)
				addr_ff <= addr_ff + 16'h0001;
			if (data_phase && byte_end && is_wr_arr) begin
				mask_ff[addr_ff[PAGE_W-1:0]] <= 1'b1;
				addr_ff[PAGE_W-1:0]          <= nxt_pg_addr;
			end
		end
	end

	// Page buffer, written only inside a frame and read only after it
	always_ff @(posedge spi_sck) begin
		if (!cs_n && step && data_phase && byte_end && is_wr_arr)
			page_mem[addr_ff[PAGE_W-1:0]] <= in_byte;
	end

	// Status crosses bit by bit; it only moves after a deselect or at the end of a write cycle
	always_ff @(posedge spi_sck or negedge rstn) begin
		if (!rstn) begin
			stat_s1_ff <= '0;
			stat_s2_ff <= '0;
		end else begin
			stat_s1_ff <= stat_ff;
			stat_s2_ff <= stat_s1_ff;
		end
	end

	// Output shifter keeps its place across a pause
	always_ff @(negedge spi_sck or negedge link_rst_n) begin
		if (!link_rst_n) begin
			so_ff     <= 1'b0;
			out_sr_ff <= 8'h00;
		end else if (hold_n && out_phase) begin
			if (cnt_ff[2:0] == 3'h0) begin
				so_ff     <= out_byte[7];
				out_sr_ff <= {out_byte[6:0], 1'b0};
			end else begin
				so_ff     <= out_sr_ff[7];
				out_sr_ff <= {out_sr_ff[6:0], 1'b0};
			end
		end
	end

	// Enable drops at once on deselect; a pause only masks it at the pin,
	// so the pending bit is driven again as soon as the pause ends
	always_ff @(negedge spi_sck or negedge link_rst_n) begin
		if (!link_rst_n)
			so_oe_ff <= 1'b0;
		else
			so_oe_ff <= out_phase;
	end

	// Pin synchronisers on the system clock
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cs_s1_ff <= 1'b1;
			cs_s2_ff <= 1'b1;
			cs_d_ff  <= 1'b1;
			wp_s1_ff <= 1'b1;
			wp_s2_ff <= 1'b1;
		end else begin
			cs_s1_ff <= cs_n;
			cs_s2_ff <= cs_s1_ff;
			cs_d_ff  <= cs_s2_ff;
			wp_s1_ff <= wp_n;
			wp_s2_ff <= wp_s1_ff;
		end
	end

	wire cs_rise  = cs_s2_ff && !cs_d_ff;
	wire cs_fall  = !cs_s2_ff && cs_d_ff;
	wire wp_low   = !wp_s2_ff;
	wire go       = cs_rise && st_ff == ST_IDLE;
	// With pin_protect_enable_bit set, a pin drop seen while selected abandons the pending status write
	wire nxt_wp_drop = (!cs_s2_ff && wp_low) || (wp_drop_ff && !cs_fall);
	wire sr_locked = stat_ff.pin_protect_enable_bit && (wp_low || wp_drop_ff);
	wire [1:0] bp_lvl = {stat_ff.block_protect_high_bit, stat_ff.block_protect_low_bit};
	wire [1:0] top_q  = addr_ff[ADDR_W-1:ADDR_W-2];
	wire page_prot = (bp_lvl == BP_QUARTER && top_q == TOP_QUARTER)
		|| (bp_lvl == BP_HALF && top_q[1]) || (bp_lvl == TOP_QUARTER);
	wire frame_ok  = cmd_ok_ff && whole_ff && stat_ff.write_latch;
	wire write_status_cmd_go   = go && is_wr_stat && sgot_ff && frame_ok && !sr_locked;
	wire wr_go     = go && is_wr_arr && |mask_ff && frame_ok && !page_prot;
	wire set_write_latch_cmd_go   = go && cmd_ok_ff && op_ff == set_write_latch_cmd;
	wire clear_write_latch_cmd_go   = go && cmd_ok_ff && op_ff == clear_write_latch_cmd;
	wire timer_end = timer_ff == TIMER_W'(WRITE_CYCLES - 1);
	wire mem_we    = st_ff == ST_PROG && wmask_ff[idx_ff];
	wire [ADDR_W-1:0] mem_waddr = {page_ff, idx_ff};

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			wp_drop_ff <= 1'b0;
		else
			wp_drop_ff <= nxt_wp_drop;
	end

	// Self-timed write cycle; timer runs from the start of the cycle
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st_ff    <= ST_IDLE;
			stat_ff  <= '0;
			idx_ff   <= '0;
			page_ff  <= '0;
			timer_ff <= '0;
			busy_ff  <= 1'b0;
			wmask_ff <= '0;
		end else begin
			unique case (st_ff)
				ST_IDLE: begin
					timer_ff <= '0;
					idx_ff   <= '0;
					if (set_write_latch_cmd_go)
						stat_ff.write_latch <= 1'b1;
					if (clear_write_latch_cmd_go)
						stat_ff.write_latch <= 1'b0;
					if (write_status_cmd_go) begin
						stat_ff.pin_protect_enable_bit <= stat_byte_ff[7];
						stat_ff.block_protect_high_bit <= stat_byte_ff[3];
						stat_ff.block_protect_low_bit  <= stat_byte_ff[2];
						stat_ff.busy <= 1'b1;
						busy_ff      <= 1'b1;
						st_ff        <= ST_WAIT;
					end
					if (wr_go) begin
						// Own copy: a status read during the sweep clears the link mask
						wmask_ff     <= mask_ff;
						page_ff      <= addr_ff[ADDR_W-1:PAGE_W];
						stat_ff.busy <= 1'b1;
						busy_ff      <= 1'b1;
						st_ff        <= ST_PROG;
					end
				end
				ST_PROG: begin
					timer_ff <= timer_ff + 21'h000001;
					idx_ff   <= idx_ff + 7'h01;
					if (&idx_ff)
						st_ff <= ST_WAIT;
				end
				ST_WAIT: begin
					timer_ff <= timer_ff + 21'h000001;
					if (timer_end) begin
						stat_ff.busy        <= 1'b0;
						stat_ff.write_latch <= 1'b0;
						busy_ff             <= 1'b0;
						st_ff               <= ST_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (mem_we)
			mem[mem_waddr] <= page_mem[idx_ff];
	end

	assign so_o  = so_ff;
	assign so_oe = so_oe_ff & hold_n;
	assign busy  = busy_ff;

	property p_latch_clear;
		@(posedge clk_sys) disable iff (!rstn) $fell(busy_ff) |-> !stat_ff.write_latch;
	endproperty
	a_latch_clear: assert property (p_latch_clear) else $error("latch kept after write");

	property p_busy_ones;
		@(negedge spi_sck) disable iff (!rstn)
			(out_phase && is_rd_stat && stat_s2_ff.busy) |-> out_byte == STATUS_BUSY;
	endproperty
	a_busy_ones: assert property (p_busy_ones) else $error("status not all ones");

	property p_locked;
		@(posedge clk_sys) disable iff (!rstn)
			(go && is_wr_stat && stat_ff.pin_protect_enable_bit && wp_low)
			|=> !busy_ff && $stable(bp_lvl);
	endproperty
	a_locked: assert property (p_locked) else $error("status written while locked");

	property p_drop;
		@(posedge clk_sys) disable iff (!rstn)
			(go && is_wr_stat && stat_ff.pin_protect_enable_bit && wp_drop_ff) |=> !busy_ff;
	endproperty
	a_drop: assert property (p_drop) else $error("abandoned status write ran");

	property p_no_pin;
		@(posedge clk_sys) disable iff (!rstn)
			(go && is_wr_stat && sgot_ff && frame_ok && !stat_ff.pin_protect_enable_bit)
			|=> busy_ff ##0 stat_ff.pin_protect_enable_bit == $past(stat_byte_ff[7]);
	endproperty
	a_no_pin: assert property (p_no_pin) else $error("status write refused");

	property p_stable_busy;
		@(posedge clk_sys) disable iff (!rstn) (busy_ff && $past(busy_ff)) |-> $stable(bp_lvl);
	endproperty
	a_stable_busy: assert property (p_stable_busy) else $error("protect moved in cycle");

	property p_time;
		@(posedge clk_sys) disable iff (!rstn) busy_ff |-> timer_ff < TIMER_W'(WRITE_CYCLES);
	endproperty
	a_time: assert property (p_time) else $error("write cycle too long");

	property p_prog_len;
		@(posedge clk_sys) disable iff (!rstn)
			$rose(busy_ff) && st_ff == ST_PROG |-> ##128 st_ff == ST_WAIT;
	endproperty
	a_prog_len: assert property (p_prog_len) else $error("page sweep length");

	property p_desel;
		@(posedge clk_sys) disable iff (!rstn) cs_s2_ff && cs_d_ff |-> !so_oe_ff;
	endproperty
	a_desel: assert property (p_desel) else $error("output driven deselected");

	property p_pause;
		@(negedge spi_sck) disable iff (!rstn) !hold_n |-> !so_oe;
	endproperty
	a_pause: assert property (p_pause) else $error("output driven in pause");

	property p_bad;
		@(posedge spi_sck) disable iff (!rstn)
			bad_ff |-> !so_oe_ff && (!$past(bad_ff) || $stable(cnt_ff));
	endproperty
	a_bad: assert property (p_bad) else $error("activity after bad opcode");

	c_page: cover property (@(posedge clk_sys) disable iff (!rstn) wr_go);
	c_stat: cover property (@(posedge clk_sys) disable iff (!rstn) write_status_cmd_go);
	c_read: cover property (@(negedge spi_sck) disable iff (!rstn) so_oe_ff && is_rd_arr);
	c_bad:  cover property (@(posedge spi_sck) disable iff (!rstn) bad_ff);
endmodule : spi_eeprom_slave_interface

// >>> verif/spi_master_model.sv
// Serial bus master model that frames transfers for the EEPROM front end
`timescale 1ns/10ps
module spi_master_model (
	output logic      spi_sck,
	output logic      cs_n,
	output logic      si,
	output logic      hold_n,
	input  wire logic so_o,
	input  wire logic so_oe
);
	logic [7:0] txq [$];
	logic [7:0] rxq [$];
	logic       mode3      = 1'h0;
	logic       oe_in_hold = 1'h0;
	initial begin
		spi_sck = 1'h0;
		cs_n    = 1'h1;
		si      = 1'h0;
		hold_n  = 1'h1;
	end
	// Clock keeps running and data keeps changing during the pause to prove both are ignored
	task automatic pause();
		spi_sck = 1'h0;
		#16;
		hold_n = 1'h0;
		repeat (6) begin
			#16;
			spi_sck    = ~spi_sck;
			si         = ~si;
			oe_in_hold = oe_in_hold | so_oe;
		end
		#16;
		hold_n = 1'h1;
		#16;
	endtask : pause
	// Floated output is recorded as unknown so it can never match a data bit
	task automatic run(input int hold_at);
		logic [7:0] rb;
		rxq.delete();
		spi_sck = mode3;
		#13.7;
		cs_n = 1'h0;
		#32;
		foreach (txq[i]) begin
			for (int b = 7; b >= 0; b--) begin
				if (i * 8 + 7 - b == hold_at)
					pause();
				spi_sck = 1'h0;
				si      = txq[i][b];
				#32;
				spi_sck = 1'h1;
				rb[b]   = so_oe ? so_o : 1'hX;
				#32;
			end
			rxq.push_back(rb);
		end
		spi_sck = mode3;
		#32;
		cs_n = 1'h1;
		// Released data line flips so a stale bit cannot be mistaken for a driven one
		si = ~si;
		#60;
	endtask : run
endmodule : spi_master_model

// >>> verif/spi_eeprom_slave_interface_test.sv
// Self-checking bench for the serial EEPROM slave front end
`timescale 1ns/10ps
module spi_eeprom_slave_interface_test import spi_eeprom_pkg::*;;
	// Shortened write time keeps the run small; must stay above the page sweep
	localparam int WCYC = 600;
	logic        clk_sys;
	logic        rstn;
	logic        wp_n;
	logic        spi_sck;
	logic        cs_n;
	logic        si;
	logic        hold_n;
	logic        so_o;
	logic        so_oe;
	logic        busy;
	logic [15:0] a;
	int          err_count;
	int          checks;
	logic [7:0]  mem_m [int];
	spi_eeprom_slave_interface #(.WRITE_CYCLES(WCYC)) dut (
		.clk_sys(clk_sys), .rstn(rstn), .spi_sck(spi_sck), .cs_n(cs_n), .si(si),
		.hold_n(hold_n), .wp_n(wp_n), .so_o(so_o), .so_oe(so_oe), .busy(busy)
	);
	spi_master_model m (
		.spi_sck(spi_sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
		.so_o(so_o), .so_oe(so_oe)
	);
	always #2.5 clk_sys = ~clk_sys;
	task automatic stop_test();
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test
	task automatic fail_out();
		err_count++;
		$display("BAD %0t wait ran out", $time);
		stop_test();
	endtask : fail_out
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t byte %h expected %h", $time, got, exp);
		end
	endtask : cmp8
	task automatic cmp1(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t flag %b expected %b", $time, got, exp);
		end
	endtask : cmp1
	function automatic logic [7:0] exp_status(input logic en, input logic [1:0] bp,
			input logic wl);
		return {en, 3'h0, bp, wl, 1'h0};
	endfunction : exp_status
	task automatic xfer(input int hold_at);
		m.run(hold_at);
		m.txq.delete();
		cmp1(so_oe, 1'h0);
	endtask : xfer
	task automatic rd_status(input logic [7:0] exp);
		m.txq = {read_status_cmd, 8'h00, 8'h00};
		xfer(-1);
		cmp8(m.rxq[1], exp);
		cmp8(m.rxq[2], exp);
	endtask : rd_status
	task automatic wr_latch();
		m.txq = {set_write_latch_cmd};
		xfer(-1);
	endtask : wr_latch
	task automatic wr_status(input logic [7:0] v);
		wr_latch();
		m.txq = {write_status_cmd, v};
		xfer(-1);
	endtask : wr_status
	// Only accepted writes update the model; the low seven address bits wrap in the page
	task automatic wr_array(input logic [15:0] wa, input int n, input logic keep);
		logic [7:0] d;
		wr_latch();
		m.txq = {write_array_cmd, wa[15:8], wa[7:0]};
		for (int i = 0; i < n; i++) begin
			d = 8'($urandom);
			m.txq.push_back(d);
			if (keep)
				mem_m[{wa[15:7], 7'(wa[6:0] + i)}] = d;
		end
		xfer(-1);
	endtask : wr_array
	task automatic rd_array(input logic [15:0] ra, input int n, input int hold_at);
		m.txq = {read_array_cmd, ra[15:8], ra[7:0]};
		repeat (n) m.txq.push_back(8'h00);
		xfer(hold_at);
		for (int i = 0; i < n; i++)
			cmp8(m.rxq[3 + i], mem_m[16'(ra + i)]);
	endtask : rd_array
	task automatic wait_write(input logic ff);
		int n;
		n = 0;
		while (busy !== 1'h1 && n < 10) begin
			@(posedge clk_sys);
			n++;
		end
		if (busy !== 1'h1)
			fail_out();
		if (ff)
			rd_status(STATUS_BUSY);
		n = 0;
		while (busy === 1'h1 && n < WCYC + 10) begin
			@(posedge clk_sys);
			n++;
		end
		if (busy !== 1'h0)
			fail_out();
		if (!ff)
			cmp1(n > WCYC - 20 && n <= WCYC, 1'h1);
	endtask : wait_write
	task automatic no_write();
		repeat (10) @(posedge clk_sys);
		cmp1(busy, 1'h0);
	endtask : no_write
	initial begin
		#450000;
		fail_out();
	end
	initial begin
		clk_sys   = 1'h0;
		rstn      = 1'h0;
		wp_n      = 1'h1;
		err_count = 0;
		checks    = 0;
		void'($urandom(32'hCA2E7453));
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		rstn = 1'h1;
		repeat (3) @(negedge clk_sys);
		cmp1(busy, 1'h0);
		rd_status(exp_status(1'h0, BP_NONE, 1'h0));
		wr_latch();
		rd_status(exp_status(1'h0, BP_NONE, 1'h1));
		// Clear command with the ignored bit set
		m.txq = {8'h0C};
		xfer(-1);
		rd_status(exp_status(1'h0, BP_NONE, 1'h0));
		a = 16'($urandom);
		wr_array(a, PAGE_BYTES + 3, 1'h1);
		wait_write(1'h1);
		rd_status(exp_status(1'h0, BP_NONE, 1'h0));
		rd_array({a[15:7], 7'h7A}, 6, -1);
		wr_array(16'hFFFF, 1, 1'h1);
		wait_write(1'h0);
		wr_array(16'h0000, 1, 1'h1);
		wait_write(1'h0);
		rd_array(16'hFFFF, 2, -1);
		m.txq = {8'h07, 8'h00, 8'h00, 8'h00};
		xfer(-1);
		foreach (m.rxq[i]) cmp8(m.rxq[i], 8'hXX);
		m.txq = {write_array_cmd, 8'h00, 8'h00, 8'hA5};
		xfer(-1);
		no_write();
		rd_array(16'h0000, 1, -1);
		wr_status(8'h84);
		wait_write(1'h0);
		rd_status(exp_status(1'h1, BP_QUARTER, 1'h0));
		wr_array(16'hFFFF, 1, 1'h0);
		no_write();
		rd_array(16'hFFFF, 1, 28);
		@(negedge clk_sys);
		wp_n = 1'h0;
		wr_status(8'h00);
		no_write();
		rd_status(exp_status(1'h1, BP_QUARTER, 1'h1));
		@(negedge clk_sys);
		wp_n = 1'h1;
		fork
			begin
				m.txq = {write_status_cmd, 8'h00};
				xfer(-1);
			end
			begin
				// Pin comes back high before deselect, so only the drop can block
				#400;
				@(negedge clk_sys);
				wp_n = 1'h0;
				#200;
				@(negedge clk_sys);
				wp_n = 1'h1;
			end
		join
		no_write();
		@(negedge clk_sys);
		wp_n = 1'h1;
		wr_status(8'h00);
		@(negedge clk_sys);
		wp_n = 1'h0;
		wait_write(1'h0);
		rd_status(exp_status(1'h0, BP_NONE, 1'h0));
		wr_status(8'h08);
		wait_write(1'h0);
		rd_status(exp_status(1'h0, BP_HALF, 1'h0));
		m.mode3 = 1'h1;
		rd_status(exp_status(1'h0, BP_HALF, 1'h0));
		cmp1(m.oe_in_hold, 1'h0);
		stop_test();
	end
endmodule : spi_eeprom_slave_interface_test
